// ---- dct_top.sv ----
// Functional notes
// R1: 13-bit mode keeps eight high bits in high byte, five in low byte.
// R2: software ignores the top three low-byte bits in 13-bit mode.
// R3: 13-bit wrap from all ones to zero sets the overflow flag.
// R4: counter select one counts falling edges on the count pin.
// R5: counter select zero uses system clock or prescaled clock per clock select.
// R6: timer advances only with run set and gate off or irq input active.
// R7: count input levels held two clocks; event rate at most clock/4.
// R8: setting run leaves the count unchanged.
// R9: software loads start values before enabling the timer.
// R10: 16-bit mode uses all sixteen bits of both bytes.
// R11: auto-reload low byte wrap sets flag, reloads from unchanged high byte.
// R12: split mode low byte is 8-bit timer with timer a controls.
// R13: split mode high byte counts internal clocks under timer b run.
// R14: split high byte overflow sets timer b overflow flag.
// R15: in split, timer b ignores count pin, never sets its flag.
// R16: in split, timer b runs in modes 0-2, stops in mode 3.
// R17: overflow flag set by hardware, cleared by software or vectoring.
// R18: interrupt request when overflow flag set and its enable set.
// R19: irq flag set by edge or level; edge clears on vector, level follows.
// R20: type bit zero selects level, one selects edge triggering.
// R21: control register at 0x88, resets to zero, fixed bit layout.
// R22: timer b works like timer a using its own bits and irq input.
// R23: prescale gives clock/12, /4, /48 or external clock/8 synchronised.
// R24: mode field 00 13-bit, 01 16-bit, 10 reload, 11 split/inactive.
// R25: pins synchronised, falling edges from samples, at most one count per clock.
//
// Design decision made here: register access over Avalon-MM.
`timescale 1ns/1ps
module dct_top (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [9:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    input  wire logic [3:0]  byteenable,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    input  wire logic        timer_a_count_pin,
    input  wire logic        timer_b_count_pin,
    input  wire logic        ext_irq_a_input,
    input  wire logic        ext_irq_b_input,
    input  wire logic        ext_clk_pin,
    input  wire logic        timer_a_vector_ack,
    input  wire logic        timer_b_vector_ack,
    input  wire logic        ext_irq_a_vector_ack,
    input  wire logic        ext_irq_b_vector_ack,
    output logic             timer_a_irq,
    output logic             timer_b_irq,
    output logic             ext_irq_a_flag,
    output logic             ext_irq_b_flag,
    output logic             timer_b_overflow
);
    logic        rst_meta_ff;
    logic        rst_s_n_ff;
    logic [4:0]  pin_s;
    logic [4:0]  prev_ff;
    logic        ptick;
    logic [7:0]  timer_control_ff;
    logic [7:0]  timer_mode_reg_ff;
    logic [7:0]  clock_select_reg_ff;
    logic [7:0]  tla_ff;
    logic [7:0]  tha_ff;
    logic [7:0]  tlb_ff;
    logic [7:0]  thb_ff;
    logic [1:0]  irq_enable_ff;
    logic [1:0]  ext_irq_config_ff;
    logic        rd_done_ff;
    logic [31:0] readdata_ff;
    logic        tb_ovf_ff;
    logic [7:0]  nxt_timer_control;
    logic [7:0]  nxt_timer_mode_reg;
    logic [7:0]  nxt_clock_select_reg;
    logic [7:0]  nxt_tla;
    logic [7:0]  nxt_tha;
    logic [7:0]  nxt_tlb;
    logic [7:0]  nxt_thb;
    logic [1:0]  nxt_irq_enable;
    logic [1:0]  nxt_ext_irq_config;
    logic        nxt_rd_done;
    logic [31:0] nxt_readdata;
    logic        nxt_tb_ovf;
    logic [7:0]  idx;
    logic [7:0]  wbyte;
    logic        wr;
    logic [7:0]  rmux;
    logic        act_a;
    logic        act_b;
    logic        act_a_prev;
    logic        act_b_prev;
    logic        fall_a;
    logic        fall_b;
    logic        split;
    logic [1:0]  mode_b;
    logic        run_a;
    logic        run_b;
    logic        inc_a;
    logic        inc_b;
    logic        inc_h;
    logic        ovf_a;
    logic        ovf_b;
    logic        ovf_h;
    logic [16:0] step_a;
    logic [16:0] step_b;
    logic [8:0]  sum_l;
    logic [8:0]  sum_h;

    // counting step for modes 0-2: {overflow, high, low}
    function automatic logic [16:0] dct_step(input logic [1:0] m,
                                             input logic [7:0] h,
                                             input logic [7:0] l);
        logic [13:0] c13;
        logic [16:0] c16;
        logic [8:0]  c8;
        c13 = {1'b0, h, l[4:0]} + 14'h0001;
        c16 = {1'b0, h, l} + 17'h0_0001;
        c8  = {1'b0, l} + 9'h001;
        case (m)
            dct_pkg::MODE_13: dct_step = {c13[13], c13[12:5], l[7:5], c13[4:0]}; // R1 R3
            dct_pkg::MODE_16: dct_step = c16; // R10
            default:          dct_step = {c8[8], h, c8[8] ? h : c8[7:0]}; // R11
        endcase
    endfunction

    // reset release through two flip-flops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_ff <= 1'b0;
            rst_s_n_ff  <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_s_n_ff  <= rst_meta_ff;
        end
    end

    dct_sync #(
        .WIDTH (5)
    ) u_sync (
        .clk   (clk),
        .rst_n (rst_s_n_ff),
        .din   ({ext_clk_pin, ext_irq_b_input, ext_irq_a_input,
                 timer_b_count_pin, timer_a_count_pin}),
        .dout  (pin_s)
    );

    // previous synchronised samples for edge detection
    always_ff @(posedge clk or negedge rst_s_n_ff) begin
        if (!rst_s_n_ff) begin
            prev_ff <= '0;
        end else begin
            prev_ff <= pin_s;
        end
    end

    dct_prescale #(
        .CNT_W (6)
    ) u_presc (
        .clk      (clk),
        .rst_n    (rst_s_n_ff),
        .sel      (clock_select_reg_ff[dct_pkg::SCA +: 2]),
        .ext_edge (pin_s[4] & ~prev_ff[4]),
        .tick     (ptick)
    );

    // bus decode: one word per register, low byte carries data
    always_comb begin
        idx   = address[9:2];
        wbyte = writedata[7:0];
        wr    = write & byteenable[0];
        if (idx == dct_pkg::IDX_CTRL) begin
            rmux = timer_control_ff;
        end else if (idx == dct_pkg::IDX_MODE) begin
            rmux = timer_mode_reg_ff;
        end else if (idx == dct_pkg::IDX_TLA) begin
            rmux = tla_ff;
        end else if (idx == dct_pkg::IDX_TLB) begin
            rmux = tlb_ff;
        end else if (idx == dct_pkg::IDX_THA) begin
            rmux = tha_ff;
        end else if (idx == dct_pkg::IDX_THB) begin
            rmux = thb_ff;
        end else if (idx == dct_pkg::IDX_CKS) begin
            rmux = clock_select_reg_ff;
        end else if (idx == dct_pkg::IDX_IEN) begin
            rmux = {6'h00, irq_enable_ff};
        end else if (idx == dct_pkg::IDX_ECFG) begin
            rmux = {6'h00, ext_irq_config_ff};
        end else begin
            rmux = 8'h00; // unmapped reads zero
        end
        // reads take one wait cycle so read data come from a register
        nxt_rd_done  = read & ~rd_done_ff;
        nxt_readdata = (read & ~rd_done_ff) ? {24'h00_0000, rmux} : readdata_ff;
    end

    // timer engines
    always_comb begin
        act_a      = ext_irq_config_ff[0] ? pin_s[2] : ~pin_s[2];
        act_b      = ext_irq_config_ff[1] ? pin_s[3] : ~pin_s[3];
        act_a_prev = ext_irq_config_ff[0] ? prev_ff[2] : ~prev_ff[2];
        act_b_prev = ext_irq_config_ff[1] ? prev_ff[3] : ~prev_ff[3];
        fall_a     = prev_ff[0] & ~pin_s[0]; // R25
        fall_b     = prev_ff[1] & ~pin_s[1];
        split      = timer_mode_reg_ff[dct_pkg::MODE_A +: 2] == dct_pkg::MODE_SPLIT; // R24
        mode_b     = timer_mode_reg_ff[dct_pkg::MODE_B +: 2];
        run_a      = timer_control_ff[dct_pkg::TR_A]
                   & (~timer_mode_reg_ff[dct_pkg::GATE_A] | act_a); // R6
        inc_a      = run_a & (timer_mode_reg_ff[dct_pkg::CT_A] ? fall_a // R4
                   : (clock_select_reg_ff[dct_pkg::TM_A] | ptick)); // R5 R12
        if (split) begin
            // run follows the mode field, no pin and no gate
            run_b = mode_b != dct_pkg::MODE_SPLIT; // R16
            inc_b = run_b & (clock_select_reg_ff[dct_pkg::TM_B] | ptick); // R15
        end else begin
            run_b = timer_control_ff[dct_pkg::TR_B]
                  & (~timer_mode_reg_ff[dct_pkg::GATE_B] | act_b)
                  & (mode_b != dct_pkg::MODE_SPLIT); // R22
            inc_b = run_b & (timer_mode_reg_ff[dct_pkg::CT_B] ? fall_b
                  : (clock_select_reg_ff[dct_pkg::TM_B] | ptick));
        end
        inc_h   = split & timer_control_ff[dct_pkg::TR_B]
                & (clock_select_reg_ff[dct_pkg::TM_A] | ptick); // R13
        step_a  = dct_step(timer_mode_reg_ff[dct_pkg::MODE_A +: 2], tha_ff, tla_ff);
        step_b  = dct_step(mode_b, thb_ff, tlb_ff);
        sum_l   = {1'b0, tla_ff} + 9'h001;
        sum_h   = {1'b0, tha_ff} + 9'h001;
        nxt_tla = tla_ff; // R8
        nxt_tha = tha_ff;
        nxt_tlb = tlb_ff;
        nxt_thb = thb_ff;
        ovf_a   = 1'b0;
        ovf_b   = 1'b0;
        ovf_h   = 1'b0;
        if (inc_a && split) begin
            {ovf_a, nxt_tla} = sum_l; // R12
        end else if (inc_a) begin
            {ovf_a, nxt_tha, nxt_tla} = step_a;
        end
        if (inc_h) begin
            {ovf_h, nxt_tha} = sum_h; // R13
        end
        if (inc_b) begin
            {ovf_b, nxt_thb, nxt_tlb} = step_b; // R22
        end
        // a software byte write wins over a count in the same cycle
        if (wr && idx == dct_pkg::IDX_TLA) nxt_tla = wbyte;
        if (wr && idx == dct_pkg::IDX_THA) nxt_tha = wbyte;
        if (wr && idx == dct_pkg::IDX_TLB) nxt_tlb = wbyte;
        if (wr && idx == dct_pkg::IDX_THB) nxt_thb = wbyte;
        // timer b overflow still reaches baud logic while split
        nxt_tb_ovf = ovf_b; // R15
    end

    // configuration registers and control flags; hardware sets win over clears
    always_comb begin
        nxt_timer_mode_reg   = timer_mode_reg_ff;
        nxt_clock_select_reg = clock_select_reg_ff;
        nxt_irq_enable       = irq_enable_ff;
        nxt_ext_irq_config   = ext_irq_config_ff;
        nxt_timer_control    = timer_control_ff;
        if (wr && idx == dct_pkg::IDX_MODE) nxt_timer_mode_reg = wbyte;
        if (wr && idx == dct_pkg::IDX_CKS) nxt_clock_select_reg = wbyte & dct_pkg::CKS_MASK;
        if (wr && idx == dct_pkg::IDX_IEN) nxt_irq_enable = wbyte[1:0];
        if (wr && idx == dct_pkg::IDX_ECFG) nxt_ext_irq_config = wbyte[1:0];
        if (wr && idx == dct_pkg::IDX_CTRL) nxt_timer_control = wbyte; // R21
        if (timer_a_vector_ack) nxt_timer_control[dct_pkg::TF_A] = 1'b0; // R17
        if (timer_b_vector_ack) nxt_timer_control[dct_pkg::TF_B] = 1'b0;
        if (ovf_a) nxt_timer_control[dct_pkg::TF_A] = 1'b1; // R3 R11 R17
        if (split ? ovf_h : ovf_b) nxt_timer_control[dct_pkg::TF_B] = 1'b1; // R14 R15
        // edge mode: sticky, cleared by vector; level mode: follows input
        if (timer_control_ff[dct_pkg::IT_A]) begin // R20
            if (ext_irq_a_vector_ack) nxt_timer_control[dct_pkg::IE_A] = 1'b0;
            if (act_a && !act_a_prev) nxt_timer_control[dct_pkg::IE_A] = 1'b1; // R19
        end else begin
            nxt_timer_control[dct_pkg::IE_A] = act_a; // R19
        end
        if (timer_control_ff[dct_pkg::IT_B]) begin
            if (ext_irq_b_vector_ack) nxt_timer_control[dct_pkg::IE_B] = 1'b0;
            if (act_b && !act_b_prev) nxt_timer_control[dct_pkg::IE_B] = 1'b1;
        end else begin
            nxt_timer_control[dct_pkg::IE_B] = act_b;
        end
    end

    // register stage for all state
    always_ff @(posedge clk or negedge rst_s_n_ff) begin
        if (!rst_s_n_ff) begin
            timer_control_ff    <= dct_pkg::RST_VAL; // R21
            timer_mode_reg_ff   <= dct_pkg::RST_VAL;
            clock_select_reg_ff <= dct_pkg::RST_VAL;
            tla_ff              <= dct_pkg::RST_VAL;
            tha_ff              <= dct_pkg::RST_VAL;
            tlb_ff              <= dct_pkg::RST_VAL;
            thb_ff              <= dct_pkg::RST_VAL;
            irq_enable_ff       <= 2'h0;
            ext_irq_config_ff   <= 2'h0;
            rd_done_ff          <= 1'b0;
            readdata_ff         <= 32'h0000_0000;
            tb_ovf_ff           <= 1'b0;
        end else begin
            timer_control_ff    <= nxt_timer_control;
            timer_mode_reg_ff   <= nxt_timer_mode_reg;
            clock_select_reg_ff <= nxt_clock_select_reg;
            tla_ff              <= nxt_tla;
            tha_ff              <= nxt_tha;
            tlb_ff              <= nxt_tlb;
            thb_ff              <= nxt_thb;
            irq_enable_ff       <= nxt_irq_enable;
            ext_irq_config_ff   <= nxt_ext_irq_config;
            rd_done_ff          <= nxt_rd_done;
            readdata_ff         <= nxt_readdata;
            tb_ovf_ff           <= nxt_tb_ovf;
        end
    end

    // outputs; requests are levels held by the flags
    assign readdata         = readdata_ff;
    assign waitrequest      = read & ~rd_done_ff;
    assign timer_a_irq      = timer_control_ff[dct_pkg::TF_A] & irq_enable_ff[0]; // R18
    assign timer_b_irq      = timer_control_ff[dct_pkg::TF_B] & irq_enable_ff[1];
    assign ext_irq_a_flag   = timer_control_ff[dct_pkg::IE_A];
    assign ext_irq_b_flag   = timer_control_ff[dct_pkg::IE_B];
    assign timer_b_overflow = tb_ovf_ff;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_s_n_ff);

    sequence read_wait;
        read && waitrequest;
    endsequence

    AST_READ_ANSWER: // R21
        assert property (read_wait |=> !waitrequest)
        else $error("read not answered after one wait cycle");
    AST_MODE13_OVF: // R3
        assert property (!split && inc_a && timer_mode_reg_ff[1:0] == 2'h0
                         && tha_ff == 8'hFF && tla_ff[4:0] == 5'h1F
                         |=> timer_control_ff[dct_pkg::TF_A] && tha_ff == 8'h00)
        else $error("13-bit wrap did not set flag");
    AST_RELOAD: // R11
        assert property (inc_a && timer_mode_reg_ff[1:0] == 2'h2 && tla_ff == 8'hFF
                         && !(wr && idx == dct_pkg::IDX_TLA)
                         |=> tla_ff == $past(tha_ff) && tha_ff == $past(tha_ff))
        else $error("reload value wrong");
    AST_GATE_HOLD: // R6
        assert property (!run_a && !split && !write |=> $stable(tla_ff) && $stable(tha_ff))
        else $error("timer a moved while stopped");
    AST_SPLIT_HIGH: // R14
        assert property (inc_h && tha_ff == 8'hFF |=> timer_control_ff[dct_pkg::TF_B])
        else $error("split high overflow lost");
    AST_SPLIT_B_FLAG: // R15
        assert property (split && !ovf_h && !timer_control_ff[dct_pkg::TF_B]
                         && !write |=> !timer_control_ff[dct_pkg::TF_B])
        else $error("timer b flag set in split mode");
    AST_VEC_CLEAR: // R17
        assert property (timer_a_vector_ack && !ovf_a |=> !timer_control_ff[dct_pkg::TF_A])
        else $error("vector did not clear flag");
    AST_IRQ_RAISE: // R18
        assert property ($rose(timer_control_ff[dct_pkg::TF_A]) && irq_enable_ff[0]
                         |-> timer_a_irq)
        else $error("timer a request missing");
    AST_LEVEL_FLAG: // R19
        assert property (!timer_control_ff[dct_pkg::IT_A] ##1
                         !$past(timer_control_ff[dct_pkg::IT_A])
                         |-> ext_irq_a_flag == $past(act_a))
        else $error("level flag does not follow input");
endmodule // dct_top

// ---- dct_pkg.sv ----
package dct_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_CTRL = 8'h88;
    localparam logic [7:0] IDX_MODE = 8'h89;
    localparam logic [7:0] IDX_TLA  = 8'h8A;
    localparam logic [7:0] IDX_TLB  = 8'h8B;
    localparam logic [7:0] IDX_THA  = 8'h8C;
    localparam logic [7:0] IDX_THB  = 8'h8D;
    localparam logic [7:0] IDX_CKS  = 8'h8E;
    localparam logic [7:0] IDX_IEN  = 8'h90;
    localparam logic [7:0] IDX_ECFG = 8'h91;
    localparam int         ADDR_W   = 10;
    // timer_control fields
    localparam int TF_B = 7;
    localparam int TR_B = 6;
    localparam int TF_A = 5;
    localparam int TR_A = 4;
    localparam int IE_B = 3;
    localparam int IT_B = 2;
    localparam int IE_A = 1;
    localparam int IT_A = 0;
    // timer_mode_reg fields
    localparam int GATE_B = 7;
    localparam int CT_B   = 6;
    localparam int MODE_B = 4;
    localparam int GATE_A = 3;
    localparam int CT_A   = 2;
    localparam int MODE_A = 0;
    // clock_select_reg fields; bits 7 and 2 read zero
    localparam int         TM_B     = 4;
    localparam int         TM_A     = 3;
    localparam int         SCA      = 0;
    localparam logic [7:0] CKS_MASK = 8'h7B;
    // timer modes
    localparam logic [1:0] MODE_13    = 2'h0;
    localparam logic [1:0] MODE_16    = 2'h1;
    localparam logic [1:0] MODE_RLD   = 2'h2;
    localparam logic [1:0] MODE_SPLIT = 2'h3;
    // prescaler selects and divisors
    localparam logic [1:0] SCA_EXT = 2'h3;
    localparam int         DIV_12  = 12;
    localparam int         DIV_4   = 4;
    localparam int         DIV_48  = 48;
    localparam int         DIV_EXT = 8;
    localparam logic [7:0] RST_VAL = 8'h00;
endpackage

// ---- dct_sync.sv ----
`timescale 1ns/1ps
// two-stage synchroniser bank for pin inputs
module dct_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    if (WIDTH < 1) begin : g_bad
        $error("dct_sync: WIDTH must be at least 1");
    end

    // first stage feeds only the second stage
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= din; // R25
            sync_ff <= meta_ff;
        end
    end

    assign dout = sync_ff;
endmodule // dct_sync

// ---- dct_prescale.sv ----
`timescale 1ns/1ps
// shared prescaled clock enable for both timers
module dct_prescale #(
    parameter int CNT_W = 6
) (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [1:0] sel,
    input  wire logic       ext_edge,
    output logic            tick
);
    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] nxt_cnt;
    logic [CNT_W-1:0] limit;
    logic             tick_ff;
    logic             nxt_tick;
    logic             step;

    if ((1 << CNT_W) < dct_pkg::DIV_48) begin : g_bad
        $error("dct_prescale: CNT_W too small for largest divisor");
    end

    // divisor select; external source counts synchronised rising edges
    always_comb begin
        case (sel)
            2'h0:    limit = CNT_W'(dct_pkg::DIV_12 - 1); // R23
            2'h1:    limit = CNT_W'(dct_pkg::DIV_4 - 1);
            2'h2:    limit = CNT_W'(dct_pkg::DIV_48 - 1);
            default: limit = CNT_W'(dct_pkg::DIV_EXT - 1);
        endcase
        step     = (sel == dct_pkg::SCA_EXT) ? ext_edge : 1'b1;
        nxt_cnt  = cnt_ff;
        nxt_tick = 1'b0;
        if (step) begin
            if (cnt_ff >= limit) begin
                nxt_cnt  = '0;
                nxt_tick = 1'b1;
            end else begin
                nxt_cnt = cnt_ff + CNT_W'(1);
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff  <= '0;
            tick_ff <= 1'b0;
        end else begin
            cnt_ff  <= nxt_cnt;
            tick_ff <= nxt_tick;
        end
    end

    assign tick = tick_ff;
endmodule // dct_prescale

// ---- dct_pin_model.sv ----
`timescale 1ns/1ps
// far-side pins: count pins idle high, gate inputs idle inactive
module dct_pin_model (
    input  wire logic       clk,
    output logic      [1:0] cnt,
    output logic      [1:0] gate
);
    initial {cnt, gate} = 4'hF;
    // four clocks per level: twice the minimum hold, event rate clk/8
    task automatic pulses(input int b, input int n);
        for (int i = 0; i < n; i++) begin
            repeat (4) @(posedge clk);
            cnt[b] <= 1'b0;
            repeat (4) @(posedge clk);
            cnt[b] <= 1'b1;
        end
    endtask
endmodule // dct_pin_model

// ---- tb.sv ----
`timescale 1ns/1ps
module tb;
    logic        clk, read = 1'b0, write = 1'b0, rst_n = 1'b0;
    logic        xclk = 1'b0;
    logic [9:0]  address = '0;
    logic [31:0] writedata = '0, readdata;
    logic        waitrequest;
    logic [1:0]  cnt, gate;
    logic [3:0]  ack = '0;
    logic [4:0]  o;
    int          error_cnt = 0, compares = 0, b_ovf = 0;
    dct_pin_model i_pins (.clk(clk), .cnt(cnt), .gate(gate));
    dct_top i_dut (.clk(clk), .rst_n(rst_n), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(4'hF), .readdata(readdata),
        .waitrequest(waitrequest), .timer_a_count_pin(cnt[0]), .timer_b_count_pin(cnt[1]),
        .ext_irq_a_input(gate[0]), .ext_irq_b_input(gate[1]), .ext_clk_pin(xclk),
        .timer_a_vector_ack(ack[0]), .timer_b_vector_ack(ack[1]),
        .ext_irq_a_vector_ack(ack[2]), .ext_irq_b_vector_ack(ack[3]), .timer_a_irq(o[0]),
        .timer_b_irq(o[1]), .ext_irq_a_flag(o[2]), .ext_irq_b_flag(o[3]),
        .timer_b_overflow(o[4]));
    // 200 MHz system clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // timer b overflow pulses, one cycle each
    always @(posedge clk) if (o[4] === 1'b1) b_ovf++;
    task automatic chk(input string nm, input logic [7:0] got, want);
        compares++;
        if (got !== want) $display("Error %s expected %h seen %h", nm, want, got);
        if (got !== want) error_cnt++;
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        @(posedge clk);
        address   <= {idx, 2'b00};
        writedata <= {24'h00_0000, d};
        write     <= 1'b1;
        do @(posedge clk); while (waitrequest !== 1'b0);
        write <= 1'b0;
    endtask
    // read data taken at the edge where waitrequest is seen low
    task automatic rd(input logic [7:0] idx, input logic [7:0] want, input string nm);
        @(posedge clk);
        address <= {idx, 2'b00};
        read    <= 1'b1;
        do @(posedge clk); while (waitrequest !== 1'b0);
        read <= 1'b0;
        chk(nm, readdata[7:0], want);
    endtask
    task automatic setup(input logic [7:0] md, lo, hi, tc);
        wr(8'h89, md);
        wr(8'h8A, lo);
        wr(8'h8C, hi);
        wr(8'h88, tc);
    endtask
    task automatic finish_test();
        $display("error_cnt %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // watchdog: the scenarios need well under two thousand cycles
    initial begin
        #50000;
        error_cnt++;
        finish_test();
    end
    // reset value, unmapped place, 16-bit on system clock wraps after six counts
    task automatic t_regs();
        rd(8'h88, 8'h00, "ctrl reset");
        wr(8'h87, 8'hFF);
        rd(8'h87, 8'h00, "unmapped");
        wr(8'h8E, 8'h08);
        wr(dct_pkg::IDX_IEN, 8'h01);
        setup(8'h01, 8'hFA, 8'hFF, 8'h10);
        repeat (20) @(posedge clk);
        rd(8'h88, 8'h30, "tf_a");
        chk("irq_a", {7'h00, o[0]}, 8'h01);
        wr(8'h88, 8'h00);
        rd(8'h88, 8'h00, "tf_a clear");
        // external clock /8: 24 rising edges give 3 ticks whatever the divider phase
        wr(8'h8E, 8'h03);
        setup(8'h01, 8'h00, 8'h00, 8'h10);
        repeat (48) begin
            repeat (4) @(posedge clk);
            xclk <= ~xclk;
        end
        rd(8'h8A, 8'h03, "ext prescale");
        wr(8'h88, 8'h00);
        wr(8'h8E, 8'h08);
    endtask
    // pin counting: stop, resume without reset, gate by the irq input
    task automatic t_count();
        setup(8'h05, 8'h00, 8'h00, 8'h10);
        i_pins.pulses(0, 5);
        wr(8'h88, 8'h00);
        i_pins.pulses(0, 2);
        rd(8'h8A, 8'h05, "count");
        wr(8'h88, 8'h10);
        i_pins.pulses(0, 3);
        rd(8'h8A, 8'h08, "resume");
        wr(8'h89, 8'h0D);
        i_pins.pulses(0, 2);
        rd(8'h8A, 8'h08, "gated");
        i_pins.gate[0] <= 1'b0;
        i_pins.pulses(0, 2);
        rd(8'h8A, 8'h0A, "gate open");
        chk("level irq", {7'h00, o[2]}, 8'h01);
        chk("level irq b", {7'h00, o[3]}, 8'h00);
        i_pins.gate[0] <= 1'b1;
        wr(8'h88, 8'h00);
        // edge mode: flag is sticky until the vector clears it
        wr(8'h88, 8'h01);
        i_pins.gate[0] <= 1'b0;
        repeat (4) @(posedge clk);
        i_pins.gate[0] <= 1'b1;
        repeat (4) @(posedge clk);
        chk("edge irq", {7'h00, o[2]}, 8'h01);
        ack[2] <= 1'b1;
        @(posedge clk);
        ack[2] <= 1'b0;
        repeat (2) @(posedge clk);
        chk("edge clear", {7'h00, o[2]}, 8'h00);
        wr(8'h88, 8'h00);
    endtask
    // modes 0..2: mode, low, high, pulses, then expected low, high, timer_control
    task automatic t_modes();
        logic [7:0] t [3][7];
        t = '{'{8'h04, 8'h1E, 8'hFF, 8'h02, 8'h00, 8'h00, 8'h30},
              '{8'h05, 8'hFE, 8'h12, 8'h03, 8'h01, 8'h13, 8'h10},
              '{8'h06, 8'hFE, 8'h80, 8'h03, 8'h81, 8'h80, 8'h30}};
        for (int m = 0; m < 3; m++) begin
            setup(t[m][0], t[m][1], t[m][2], 8'h10);
            i_pins.pulses(0, t[m][3]);
            rd(8'h8A, t[m][4], "low");
            rd(8'h8C, t[m][5], "high");
            rd(8'h88, t[m][6], "flag");
            wr(8'h88, 8'h00);
        end
    endtask
    // split: high byte runs under timer b run, overflow lands in timer b flag
    task automatic t_split();
        // timer b runs without its run bit, overflows, but leaves its flag alone
        wr(8'h8B, 8'hFF);
        wr(8'h8D, 8'hFF);
        wr(dct_pkg::IDX_IEN, 8'h03);
        wr(8'h89, 8'h13);
        repeat (15) @(posedge clk);
        rd(8'h88, 8'h00, "tf_b untouched");
        chk("b overflow", b_ovf[7:0], 8'h01);
        setup(8'h13, 8'h00, 8'hF0, 8'h40);
        repeat (30) @(posedge clk);
        rd(8'h88, 8'hC0, "tf_b split");
        chk("irq_b", {7'h00, o[1]}, 8'h01);
        @(posedge clk);
        ack[1] <= 1'b1;
        @(posedge clk);
        ack[1] <= 1'b0;
        rd(8'h88, 8'h40, "tf_b vector");
        chk("irq_b off", {7'h00, o[1]}, 8'h00);
        wr(8'h88, 8'h00);
    endtask
    // reset held twelve cycles, then the scenarios
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        // level flags follow the pins only once the synchronisers have filled
        repeat (8) @(posedge clk);
        t_regs();
        t_count();
        t_modes();
        t_split();
        finish_test();
    end
endmodule // tb
